// ===== verilog/bridge_diag_regs.sv
`timescale 1ns/1ps
`include "bridge_diag_cfg.svh"
// Overview of operation
// RQ1 - off-state open load runs unless disable set
// RQ2 - every serial word carries odd parity bit
// RQ3 - supply verify bits activate monitor checks
// RQ4 - bridge verify bit write activates and initiates
// RQ5 - phase select picks open load phase
// RQ6 - connect result register read-only, detected as 1
// RQ7 - state result register read-only, reset zero
// RQ8 - gate mask bit 1 suppresses its fault
// RQ9 - supply drain mask bit 1 suppresses fault
// RQ10 - gate flags register shows gate undervoltage faults
// RQ11 - regulator drain flags register shows faults
// RQ12 - supply load flags register shows faults
// RQ13 - bootstrap manager active while disable bit 0
// RQ14 - stop on fail halts bridge on fault
// RQ15 - control holds four gate drive commands
// RQ16 - status word bit positions as listed
// RQ17 - status resets flag and reset bits set
// RQ18 - status bits read-only, 1 means fault
// RQ19 - summary status bits from diagnostic flags
// RQ20 - address high nibble, bit 11 writes, RO ignored
module bridge_diag_regs
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // serial link
    input wire logic i_strobe_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_en,
    // fault monitors: index 0 a low, 1 a high, 2 b low, 3 b high
    input wire logic [3:0] i_gate_under,
    input wire logic [3:0] i_drain_over,
    input wire logic i_regulator_over,
    input wire logic i_regulator_under,
    input wire logic i_supply_over,
    input wire logic i_supply_under,
    input wire logic i_a_bootstrap_under,
    input wire logic i_b_bootstrap_under,
    input wire logic i_a_overcurrent,
    input wire logic i_b_overcurrent,
    input wire logic i_open_load,
    input wire logic i_temp_warning,
    input wire logic i_logic_over,
    input wire logic i_overtemp,
    input wire logic i_watchdog_timeout,
    // verification results: pbc, pac, vbr, lsd1, lsd0 / sbs, sas, sad
    input wire logic [4:0] i_verify_connect,
    input wire logic [2:0] i_verify_state,
    // verification controls
    output logic [7:0] o_verify_supply,
    output logic [8:0] o_verify_bridge,
    output logic o_verify_start,
    output logic o_openload_phase_b,
    output logic o_offstate_openload_run,
    // bridge controls: b high, b low, a high, a low
    output logic o_bootstrap_manager_enable,
    output logic o_bridge_stop,
    output logic [3:0] o_gate_drive
);
    import bridge_diag_pkg::*;

    word_t verify_command_supply;
    word_t verify_command_bridge;
    word_t verify_result_connect;
    word_t verify_result_state;
    word_t fault_mask_gate;
    word_t fault_mask_supply_drain;
    word_t bridge_control;
    word_t status_word;
    word_t read_data;
    word_t tx_word;
    word_t rx_word;
    word_t shown;
    logic [3:0] resp_addr;
    logic [3:0] shown_addr;
    resp_kind_t resp_kind;
    resp_kind_t shown_kind;
    logic por;
    logic serial_error;
    logic frame_start;
    logic frame_done;
    logic frame_ok;
    logic wr_ok;
    logic [3:0] rx_addr;
    logic any_fault;
    logic [`FLT_W-1:0] raw;
    logic [`FLT_W-1:0] mask_vec;
    logic [`FLT_W-1:0] clr;
    logic [`FLT_W-1:0] flt;

    serial_port u_serial
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_strobe_n(i_strobe_n),
        .i_sck(i_sck),
        .i_sdi(i_sdi),
        .o_sdo(o_sdo),
        .o_sdo_en(o_sdo_en),
        .i_tx_word(tx_word),
        .o_frame_start(frame_start),
        .o_frame_done(frame_done),
        .o_frame_ok(frame_ok),
        .o_rx_word(rx_word)
    );

    fault_latch u_faults
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_raw(raw),
        .i_mask(mask_vec),
        .i_clear(clr),
        .o_flags(flt)
    );

    assign rx_addr = rx_word[`WORD_ADDR_HI:`WORD_ADDR_LO];
    assign wr_ok = frame_done & frame_ok & rx_word[`WORD_WRITE_BIT]; // [RQ20]

    assign raw = {i_logic_over, i_temp_warning, i_open_load,
                  i_b_overcurrent, i_a_overcurrent,
                  i_b_bootstrap_under, i_a_bootstrap_under,
                  i_supply_under, i_supply_over,
                  i_regulator_under, i_regulator_over,
                  i_drain_over, i_gate_under};

    // route each mask bit onto the faults it covers
    assign mask_vec = {fault_mask_supply_drain[7], fault_mask_gate[7],
                       3'b000,
                       {2{fault_mask_gate[8]}},
                       {2{fault_mask_supply_drain[8]}},
                       fault_mask_supply_drain[9],
                       fault_mask_supply_drain[10],
                       fault_mask_supply_drain[4:1],
                       fault_mask_gate[4:1]}; // [RQ8] [RQ9]

    assign any_fault = (|flt) | i_overtemp;

    // summary bits, 1 means a fault is present
    always_comb
    begin
        status_word = 16'h0000;
        status_word[14] = por;
        status_word[13] = serial_error;
        status_word[11] = i_overtemp;
        status_word[10] = flt[`FI_TEMP_WARN];
        status_word[9] = flt[`FI_SUP_OVER] | flt[`FI_SUP_UNDER]; // [RQ19]
        status_word[8] = flt[`FI_LOGIC_OVER];
        status_word[7] = i_watchdog_timeout;
        status_word[6] = flt[`FI_REG_OVER] | flt[`FI_REG_UNDER]; // [RQ19]
        status_word[4] = flt[`FI_OC_A] | flt[`FI_OC_B]
                         | flt[`FI_OPEN_LOAD]; // [RQ19]
        status_word[3] = flt[`FI_BOOT_A] | flt[`FI_BOOT_B]; // [RQ19]
        status_word[2] = |flt[3:0]; // [RQ19]
        status_word[1] = |flt[7:4]; // [RQ19]
        status_word[15] = |status_word[14:1]; // [RQ16] [RQ18]
    end

    // register contents as read back
    always_comb
    begin
        read_data = 16'h0000;
        case (resp_addr)
            `ADDR_CONFIG5:
                read_data[`OFFSTATE_OL_DISABLE_BIT] = ~o_offstate_openload_run;
            `ADDR_VERIFY_SUPPLY: read_data = verify_command_supply;
            `ADDR_VERIFY_BRIDGE: read_data = verify_command_bridge;
            `ADDR_RESULT_CONNECT: read_data = verify_result_connect; // [RQ6]
            `ADDR_RESULT_STATE: read_data = verify_result_state; // [RQ7]
            `ADDR_MASK_GATE: read_data = fault_mask_gate;
            `ADDR_MASK_SUPPLY_DRAIN: read_data = fault_mask_supply_drain;
            `ADDR_FLAGS_GATE: read_data[4:1] = flt[3:0]; // [RQ10]
            `ADDR_FLAGS_REG_DRAIN:
                read_data = {5'b00000, flt[`FI_REG_OVER], flt[`FI_REG_UNDER],
                             4'h0, flt[7:4], 1'b0}; // [RQ11]
            `ADDR_FLAGS_SUPPLY_LOAD:
                read_data = {5'b00000, flt[`FI_SUP_OVER], flt[`FI_SUP_UNDER],
                             1'b0, flt[`FI_BOOT_B], flt[`FI_BOOT_A], 2'b00,
                             flt[`FI_OC_B], flt[`FI_OC_A],
                             flt[`FI_OPEN_LOAD], 1'b0}; // [RQ12]
            `ADDR_BRIDGE_CONTROL: read_data = bridge_control;
            default: read_data = 16'h0000;
        endcase
    end

    // outgoing word: status after writes and errors, else the register read
    always_comb
    begin
        tx_word = 16'h0000;
        unique case (resp_kind)
            RESP_STATUS: tx_word[15:1] = status_word[15:1]; // [RQ16]
            RESP_REG:
                tx_word[15:1] = {resp_addr, 1'b0, read_data[10:1]};
        endcase
        tx_word[0] = odd_fill(tx_word[15:1]); // [RQ2]
    end

    // flags shown in a good frame are cleared when it ends, except those only summed into a status summary bit
    always_comb
    begin
        clr = '0;
        if (frame_done && frame_ok)
        begin
            unique case (shown_kind)
                RESP_STATUS:
                begin
                    clr[`FI_TEMP_WARN] = shown[10];
                    clr[`FI_LOGIC_OVER] = shown[8];
                end
                RESP_REG:
                begin
                    if (shown_addr == `ADDR_FLAGS_GATE)
                    begin
                        clr[3:0] = shown[4:1];
                    end
                    if (shown_addr == `ADDR_FLAGS_REG_DRAIN)
                    begin
                        clr[7:4] = shown[4:1];
                        clr[`FI_REG_OVER] = shown[10];
                        clr[`FI_REG_UNDER] = shown[9];
                    end
                    if (shown_addr == `ADDR_FLAGS_SUPPLY_LOAD)
                    begin
                        clr[`FI_SUP_OVER] = shown[10];
                        clr[`FI_SUP_UNDER] = shown[9];
                        clr[`FI_BOOT_B] = shown[7];
                        clr[`FI_BOOT_A] = shown[6];
                        clr[`FI_OC_B] = shown[3];
                        clr[`FI_OC_A] = shown[2];
                        clr[`FI_OPEN_LOAD] = shown[1];
                    end
                end
            endcase
        end
    end

    // frame bookkeeping: what was sent and what is sent next
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            shown <= 16'h0000;
            shown_addr <= 4'h0;
            shown_kind <= RESP_STATUS;
            resp_addr <= 4'h0;
            resp_kind <= RESP_STATUS;
        end
        else if (frame_start)
        begin
            shown <= tx_word;
            shown_addr <= resp_addr;
            shown_kind <= resp_kind;
        end
        else if (frame_done)
        begin
            resp_addr <= rx_addr;
            if (frame_ok && !rx_word[`WORD_WRITE_BIT])
            begin
                resp_kind <= RESP_REG;
            end
            else
            begin
                resp_kind <= RESP_STATUS;
            end
        end
    end

    // reset and serial error bits, a new error beats the clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            por <= 1'b1; // [RQ17]
            serial_error <= 1'b0;
        end
        else if (frame_done)
        begin
            if (!frame_ok)
            begin
                serial_error <= 1'b1; // [RQ2]
            end
            else if (shown_kind == RESP_STATUS)
            begin
                por <= 1'b0;
                serial_error <= 1'b0;
            end
        end
    end

    // writable registers, read-only numbers fall through untouched
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            verify_command_supply <= `ZERO_WORD;
            verify_command_bridge <= `ZERO_WORD;
            fault_mask_gate <= `ZERO_WORD;
            fault_mask_supply_drain <= `ZERO_WORD;
            bridge_control <= `CONTROL_RESET; // [RQ17]
            o_offstate_openload_run <= 1'b1;
        end
        else if (wr_ok)
        begin
            case (rx_addr) // [RQ20]
                `ADDR_CONFIG5:
                    o_offstate_openload_run <=
                        ~rx_word[`OFFSTATE_OL_DISABLE_BIT]; // [RQ1]
                `ADDR_VERIFY_SUPPLY:
                    verify_command_supply <=
                        rx_word & `WMASK_VERIFY_SUPPLY; // [RQ3]
                `ADDR_VERIFY_BRIDGE:
                    verify_command_bridge <=
                        rx_word & `WMASK_VERIFY_BRIDGE; // [RQ4]
                `ADDR_MASK_GATE:
                    fault_mask_gate <= rx_word & `WMASK_MASK_GATE; // [RQ8]
                `ADDR_MASK_SUPPLY_DRAIN:
                    fault_mask_supply_drain <=
                        rx_word & `WMASK_MASK_SUPPLY_DRAIN; // [RQ9]
                `ADDR_BRIDGE_CONTROL:
                    bridge_control <= rx_word & `WMASK_CONTROL; // [RQ15]
                default:
                begin
                end
            endcase
        end
    end

    // verification results follow the monitors every cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            verify_result_connect <= `ZERO_WORD;
            verify_result_state <= `ZERO_WORD;
        end
        else
        begin
            verify_result_connect <= {9'h000, i_verify_connect[4:2], 1'b0,
                                      i_verify_connect[1:0], 1'b0}; // [RQ6]
            verify_result_state <= {10'h000, i_verify_state[2:1], 2'b00,
                                    i_verify_state[0], 1'b0}; // [RQ7]
        end
    end

    // a write carrying any bridge test bit launches the check
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_verify_start <= 1'b0;
        end
        else
        begin
            o_verify_start <= wr_ok && rx_addr == `ADDR_VERIFY_BRIDGE
                              && |(rx_word & `TEST_BITS_BRIDGE); // [RQ4]
        end
    end

    assign o_verify_supply = verify_command_supply[10:3]; // [RQ3]
    assign o_verify_bridge = {verify_command_bridge[9:6],
                              verify_command_bridge[4:1], 1'b0}; // [RQ4]
    assign o_openload_phase_b =
        verify_command_bridge[`OPENLOAD_PHASE_SELECT_BIT]; // [RQ5]

    // bridge drive, halted on a fault while stop on fail is set
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_bootstrap_manager_enable <= 1'b1;
            o_bridge_stop <= 1'b0;
            o_gate_drive <= 4'h0;
        end
        else
        begin
            o_bootstrap_manager_enable <=
                ~bridge_control[`CTRL_BOOT_MGR_DISABLE_BIT]; // [RQ13]
            o_bridge_stop <= bridge_control[`CTRL_STOP_ON_FAIL_BIT]
                             & any_fault; // [RQ14]
            if (bridge_control[`CTRL_STOP_ON_FAIL_BIT] && any_fault)
            begin
                o_gate_drive <= 4'h0; // [RQ14]
            end
            else
            begin
                o_gate_drive <= bridge_control[4:1]; // [RQ15]
            end
        end
    end

    sequence s_good_write(logic [3:0] a);
        wr_ok && rx_addr == a;
    endsequence

    a_tx_odd_parity: assert property (@(posedge i_ref_clk) // [RQ2]
        disable iff (!i_rst_n) frame_start |-> ^tx_word)
        else $error("outgoing word has even parity");

    a_error_flagged: assert property (@(posedge i_ref_clk) // [RQ2]
        disable iff (!i_rst_n) frame_done && !frame_ok |=> serial_error)
        else $error("bad frame did not raise serial error");

    a_openload_disable: assert property (@(posedge i_ref_clk) // [RQ1]
        disable iff (!i_rst_n) s_good_write(`ADDR_CONFIG5)
        |=> o_offstate_openload_run == !$past(rx_word[9]))
        else $error("off-state open load run not updated");

    a_phase_select: assert property (@(posedge i_ref_clk) // [RQ5]
        disable iff (!i_rst_n) s_good_write(`ADDR_VERIFY_BRIDGE)
        |=> o_openload_phase_b == $past(rx_word[10]) ##1 !o_verify_start)
        else $error("phase select or start pulse wrong");

    a_ro_ignored: assert property (@(posedge i_ref_clk) // [RQ20]
        disable iff (!i_rst_n) wr_ok && rx_addr inside {4'h8, 4'h9, 4'hc,
        4'hd, 4'he} |=> $stable(bridge_control) && $stable(fault_mask_gate)
        && $stable(verify_command_supply))
        else $error("write to read-only register changed state");

    a_boot_manager: assert property (@(posedge i_ref_clk) // [RQ13]
        disable iff (!i_rst_n) s_good_write(`ADDR_BRIDGE_CONTROL)
        |=> ##1 o_bootstrap_manager_enable == !$past(rx_word[8], 2))
        else $error("bootstrap manager enable wrong");

    a_stop_drive: assert property (@(posedge i_ref_clk) // [RQ14]
        disable iff (!i_rst_n) o_bridge_stop |-> o_gate_drive == 4'h0)
        else $error("gate drive active while bridge stopped");

    a_por_clear: assert property (@(posedge i_ref_clk) // [RQ17]
        disable iff (!i_rst_n) $fell(por)
        |-> $past(frame_done && frame_ok && shown_kind == RESP_STATUS))
        else $error("reset flag cleared without status read");

    a_flag_summary: assert property (@(posedge i_ref_clk) // [RQ16]
        disable iff (!i_rst_n) frame_start && resp_kind == RESP_STATUS
        |-> tx_word[15] == (por || serial_error || i_overtemp
        || i_watchdog_timeout || (|flt)))
        else $error("diagnostic flag disagrees with status bits");

endmodule

// ===== verilog/bridge_diag_cfg.svh
`ifndef BRIDGE_DIAG_CFG_SVH
`define BRIDGE_DIAG_CFG_SVH

// serial word layout
`define FRAME_BITS 5'd16
`define WORD_ADDR_HI 15
`define WORD_ADDR_LO 12
`define WORD_WRITE_BIT 11
`define DATA_FIELD 16'h07fe

// register numbers
`define ADDR_CONFIG5 4'h5
`define ADDR_VERIFY_SUPPLY 4'h6
`define ADDR_VERIFY_BRIDGE 4'h7
`define ADDR_RESULT_CONNECT 4'h8
`define ADDR_RESULT_STATE 4'h9
`define ADDR_MASK_GATE 4'ha
`define ADDR_MASK_SUPPLY_DRAIN 4'hb
`define ADDR_FLAGS_GATE 4'hc
`define ADDR_FLAGS_REG_DRAIN 4'hd
`define ADDR_FLAGS_SUPPLY_LOAD 4'he
`define ADDR_BRIDGE_CONTROL 4'hf

// writable field masks
`define WMASK_VERIFY_SUPPLY 16'h07f8
`define WMASK_VERIFY_BRIDGE 16'h07de
`define TEST_BITS_BRIDGE 16'h03de
`define WMASK_MASK_GATE 16'h019e
`define WMASK_MASK_SUPPLY_DRAIN 16'h079e
`define WMASK_CONTROL 16'h019e

// field positions
`define OFFSTATE_OL_DISABLE_BIT 9
`define OPENLOAD_PHASE_SELECT_BIT 10
`define CTRL_BOOT_MGR_DISABLE_BIT 8
`define CTRL_STOP_ON_FAIL_BIT 7

// reset values
`define CONTROL_RESET 16'h0080
`define ZERO_WORD 16'h0000

// latched fault vector positions
`define FLT_W 19
`define FI_REG_OVER 8
`define FI_REG_UNDER 9
`define FI_SUP_OVER 10
`define FI_SUP_UNDER 11
`define FI_BOOT_A 12
`define FI_BOOT_B 13
`define FI_OC_A 14
`define FI_OC_B 15
`define FI_OPEN_LOAD 16
`define FI_TEMP_WARN 17
`define FI_LOGIC_OVER 18

`endif

// ===== verilog/bridge_diag_pkg.sv
package bridge_diag_pkg;

    typedef logic [15:0] word_t;

    typedef enum logic {
        RESP_STATUS = 1'b0,
        RESP_REG = 1'b1
    } resp_kind_t;

    // value of bit 0 that gives the whole word an odd count of ones
    function automatic logic odd_fill(input logic [15:1] d);
        return ~(^d);
    endfunction

endpackage

// ===== verilog/serial_port.sv
`timescale 1ns/1ps
`include "bridge_diag_cfg.svh"
module serial_port
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // serial pins
    input wire logic i_strobe_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_en,
    // word side
    input wire bridge_diag_pkg::word_t i_tx_word,
    output logic o_frame_start,
    output logic o_frame_done,
    output logic o_frame_ok,
    output bridge_diag_pkg::word_t o_rx_word
);
    import bridge_diag_pkg::*;

    logic strobe_q;
    logic sck_q;
    logic [4:0] bit_count;
    word_t tx_shift;

    assign o_frame_start = strobe_q & ~i_strobe_n;
    assign o_frame_done = ~strobe_q & i_strobe_n;
    // exactly sixteen clocks and odd parity over the word
    assign o_frame_ok = (bit_count == `FRAME_BITS) & (^o_rx_word); // [RQ2]
    assign o_sdo = tx_shift[15];

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            strobe_q <= 1'b1;
            sck_q <= 1'b0;
            o_sdo_en <= 1'b0;
        end
        else
        begin
            strobe_q <= i_strobe_n;
            sck_q <= i_sck;
            o_sdo_en <= ~i_strobe_n;
        end
    end

    // receive on rising clock edge, count saturates past the frame size
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_count <= 5'h00;
            o_rx_word <= 16'h0000;
        end
        else if (o_frame_start)
        begin
            bit_count <= 5'h00;
        end
        else if (!i_strobe_n && !sck_q && i_sck)
        begin
            o_rx_word <= {o_rx_word[14:0], i_sdi};
            if (bit_count != 5'h1f)
            begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    // transmit shifts on falling clock edge
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_shift <= 16'h0000;
        end
        else if (o_frame_start)
        begin
            tx_shift <= i_tx_word;
        end
        else if (!i_strobe_n && sck_q && !i_sck)
        begin
            tx_shift <= {tx_shift[14:0], 1'b0};
        end
    end

    a_frame_count: assert property (@(posedge i_ref_clk) // [RQ2]
        disable iff (!i_rst_n)
        !i_strobe_n && !o_frame_start && !sck_q && i_sck
        && bit_count < `FRAME_BITS |=> bit_count == $past(bit_count) + 5'd1)
        else $error("received bit not counted");

endmodule

// ===== verilog/fault_latch.sv
`timescale 1ns/1ps
`include "bridge_diag_cfg.svh"
module fault_latch
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // fault events, masks and read clears
    input wire logic [`FLT_W-1:0] i_raw,
    input wire logic [`FLT_W-1:0] i_mask,
    input wire logic [`FLT_W-1:0] i_clear,
    output logic [`FLT_W-1:0] o_flags
);
    import bridge_diag_pkg::*;

    genvar g;
    generate
        for (g = 0; g < `FLT_W; g++)
        begin : g_bit
            logic set;
            // a masked fault is never detected
            assign set = i_raw[g] & ~i_mask[g]; // [RQ8] [RQ9]
            // a new event beats a read clear in the same cycle
            always_ff @(posedge i_ref_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    o_flags[g] <= 1'b0;
                end
                else
                begin
                    o_flags[g] <= set | (o_flags[g] & ~i_clear[g]);
                end
            end
            a_masked_no_set: assert property (@(posedge i_ref_clk) // [RQ8]
                disable iff (!i_rst_n)
                $rose(o_flags[g]) |-> $past(i_raw[g]) && !$past(i_mask[g]))
                else $error("fault flag set while masked or absent");
        end
    endgenerate

endmodule

// ===== test/host_model.sv
`timescale 1ns/1ps
// serial host: one whole frame per call, answer collected msb first
module host_model
(
    // clock
    input wire logic i_ref_clk,
    // serial pins
    input wire logic i_sdo,
    output logic o_strobe_n,
    output logic o_sck,
    output logic o_sdi
);
    // set by the bench to send one word with wrong parity
    logic flip = 1'b0;
    task automatic xf(input logic [15:1] w, output logic [15:0] a);
        logic [15:0] f;
        f = {w, ~(^w) ^ flip};
        @(posedge i_ref_clk) o_strobe_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        for (int i = 15; i >= 0; i--)
        begin
            a[i] = i_sdo;
            o_sdi <= f[i];
            o_sck <= 1'b1;
            repeat (2) @(posedge i_ref_clk);
            o_sck <= 1'b0;
            repeat (2) @(posedge i_ref_clk);
        end
        o_strobe_n <= 1'b1;
        // data line left at the inverse of the last bit between frames
        o_sdi <= ~f[0];
        repeat (3) @(posedge i_ref_clk);
    endtask
    initial
    begin
        o_strobe_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bridge_diag_pkg::*;
    logic clk, rst_n, d2, stb_n, sck, sdi, sdo, ol_b, run, bm, stop;
    logic sdo_en, vst, lv, stb_q = 1'b1;
    integer n_start = 0;
    logic [3:0] gu, dro, drv;
    logic [4:0] vc;
    logic [2:0] vs;
    logic [7:0] vsup;
    logic [8:0] bridge_supply_disconnect;
    word_t ans;
    int num_errors = 0, n_compared = 0, cyc = 0;
    bridge_diag_regs uut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_strobe_n(stb_n), .i_sck(sck), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_en(sdo_en), .i_gate_under(gu), .i_drain_over(dro),
        .i_regulator_over(dro[0]), .i_regulator_under(d2),
        .i_supply_over(d2), .i_supply_under(d2),
        .i_a_bootstrap_under(d2), .i_b_bootstrap_under(d2),
        .i_a_overcurrent(d2), .i_b_overcurrent(d2), .i_open_load(d2),
        .i_temp_warning(d2), .i_logic_over(d2), .i_overtemp(lv),
        .i_watchdog_timeout(lv), .i_verify_connect(vc),
        .i_verify_state(vs), .o_verify_supply(vsup), .o_verify_bridge(bridge_supply_disconnect),
        .o_verify_start(vst), .o_openload_phase_b(ol_b),
        .o_offstate_openload_run(run), .o_bootstrap_manager_enable(bm),
        .o_bridge_stop(stop), .o_gate_drive(drv));
    host_model host (.i_ref_clk(clk), .i_sdo(sdo), .o_strobe_n(stb_n),
        .o_sck(sck), .o_sdi(sdi));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic word_t odd(word_t s);
        return {s[15:1], ~(^s[15:1])};
    endfunction
    task automatic end_sim;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input word_t v);
        host.xf({a, 1'b1, v[10:1]}, ans);
    endtask
    // second frame carries the answer to the first
    task automatic rd(input logic [3:0] a, input word_t v);
        host.xf({a, 11'h0}, ans);
        host.xf({a, 11'h0}, ans);
        chk(ans, odd({a, 1'b0, v[10:1], 1'b0}));
    endtask
    task automatic pulse;
        @(posedge clk) {gu, dro, d2} <= 9'h1ff;
        repeat (3) @(posedge clk);
        {gu, dro, d2} <= 9'h0;
        @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        stb_q <= stb_n;
        n_start <= n_start + vst;
        if (sdo_en !== !stb_q)
            chk(sdo_en, !stb_q);
        if (cyc == 6000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        {rst_n, gu, dro, d2, vc, vs, lv} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({run, bm, stop, drv}, 16'h0060);
        host.xf({4'hf, 11'h0}, ans);
        chk(ans, 16'hc001);
        rd(4'hf, 16'h0080);
        host.flip = 1'b1;
        wr(4'hf, 16'h0000);
        host.flip = 1'b0;
        host.xf({4'hf, 11'h0}, ans);
        chk(ans, odd(16'ha000));
        rd(4'hf, 16'h0080);
        $display("reset test done");
        wr(4'h5, 16'h0200);
        chk(run, 1'b0);
        rd(4'h5, 16'h0200);
        wr(4'h6, 16'h07f8);
        wr(4'h7, 16'h07de);
        chk({vsup, ol_b, bridge_supply_disconnect}, 18'h3fffe);
        rd(4'h6, 16'h07f8);
        rd(4'h7, 16'h07de);
        wr(4'h5, 16'h0);
        wr(4'h7, 16'h0);
        chk({run, ol_b, bridge_supply_disconnect[1]}, 16'h0004);
        chk(n_start, 1);
        wr(4'hf, 16'h011e);
        chk({bm, stop, drv}, 16'h000f);
        wr(4'h8, 16'h07fe);
        {vc, vs} <= 8'hff;
        rd(4'h8, 16'h0076);
        rd(4'h9, 16'h0032);
        $display("command test done");
        pulse();
        chk({stop, drv}, 16'h000f);
        wr(4'hf, 16'h009e);
        chk({stop, drv}, 16'h0010);
        lv <= 1'b1;
        host.xf({4'hf, 11'h0}, ans);
        chk(ans, odd(16'h8fde));
        lv <= 1'b0;
        rd(4'hc, 16'h001e);
        rd(4'hd, 16'h061e);
        rd(4'he, 16'h06ce);
        chk({stop, drv}, 16'h000f);
        wr(4'ha, 16'h019e);
        rd(4'ha, 16'h019e);
        wr(4'hb, 16'h079e);
        pulse();
        host.xf({4'hc, 11'h0}, ans);
        chk(ans, odd(16'h8010));
        rd(4'hc, 16'h0);
        $display("fault test done");
        end_sim();
    end
endmodule
